// File: pkg/arp_pkg.sv
// constants, register map and carrier types of the dual auto-reload pwm timer
package arp_pkg;

	localparam int CNT_W = 12;
	localparam int NUM_CH = 4;
	localparam int IRQ_W = 6;
	localparam int DT_W = 7;

	localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
	localparam logic [CNT_W-1:0] CNT_RST = 12'h000;

	// byte offsets on the register bus
	localparam logic [7:0] OFS_RELOAD_ONE_HIGH = 8'h00;
	localparam logic [7:0] OFS_RELOAD_ONE_LOW = 8'h04;
	localparam logic [7:0] OFS_OUTPUT_ENABLE = 8'h08;
	localparam logic [7:0] OFS_CSR_BASE = 8'h0C;
	localparam logic [7:0] OFS_RELOAD_TWO_HIGH = 8'h1C;
	localparam logic [7:0] OFS_RELOAD_TWO_LOW = 8'h20;
	localparam logic [7:0] OFS_DEAD_TIME = 8'h24;
	localparam logic [7:0] OFS_TRANSFER = 8'h28;
	localparam logic [7:0] OFS_MODE = 8'h2C;
	localparam logic [7:0] OFS_DUTY_BASE = 8'h30;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
	localparam logic [7:0] OFS_COUNT_ONE = 8'h48;
	localparam logic [7:0] OFS_COUNT_TWO = 8'h4C;

	// channel control/status fields
	localparam int CSR_ONE_PULSE_ENABLE_BIT = 3;
	localparam int CSR_EDGE_BIT = 2;
	localparam int CSR_POL_BIT = 1;
	localparam int CSR_CMP_BIT = 0;
	localparam int OP_CH = 3;

	// dead-time register fields
	localparam int DT_EN_BIT = 7;

	// transfer and mode register fields
	localparam int TRAN_ONE_BIT = 0;
	localparam int TRAN_TWO_BIT = 1;
	localparam int DUAL_EN_BIT = 0;

	// interrupt status layout
	localparam int IRQ_OVF_ONE = 0;
	localparam int IRQ_OVF_TWO = 1;
	localparam int IRQ_CMP_BASE = 2;

	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_TRANSFER = 2'h3;
	localparam logic [IRQ_W-1:0] RST_IRQ = 6'h00;

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic wrap;
		logic step;
	} arp_cnt_t;

	typedef enum logic [0:0] {
		OP_IDLE,
		OP_RUN
	} arp_op_state_t;

endpackage

// File: src/arp_counter.sv
// 12-bit up-counter that reloads from its auto-reload value on overflow
`timescale 1ns/1ps
module arp_counter
	import arp_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// control
	input wire logic run,
	input wire logic restart,
	input wire logic [CNT_W-1:0] reloadValue,
	// state
	output arp_cnt_t cnt
);

	logic [CNT_W-1:0] countQ, countD;
	logic wrapQ, wrapD;
	logic stepQ, stepD;

	always_comb begin
		countD = countQ;
		wrapD = 1'b0;
		stepD = 1'b0;
		if (restart) begin
			countD = reloadValue;
			stepD = 1'b1;
		end else if (run) begin
			stepD = 1'b1;
			if (countQ == CNT_MAX) begin
				countD = reloadValue;
				wrapD = 1'b1;
			end else begin
				countD = countQ + 12'h001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			countQ <= CNT_RST;
			wrapQ <= 1'b0;
			stepQ <= 1'b0;
		end else begin
			countQ <= countD;
			wrapQ <= wrapD;
			stepQ <= stepD;
		end
	end

	assign cnt = '{count: countQ, wrap: wrapQ, step: stepQ};

endmodule

// File: src/arp_timer.sv
// dual auto-reload pwm timer with wishbone register access
`timescale 1ns/1ps

// What this block does
// - Counter one reloads from the 12-bit first reload value on overflow, setting its period.
// - Counter two reloads from the second reload value and in dual mode times channels 2 and 3.
// - Output enables reset to 0; at 0 the pin is left to general I/O, at 1 the pwm drives it.
// - Bit 3 of channel three's register enables one-pulse on channels 2 and 3, reset 0.
// - Bit 2 picks the capture edge that fires a pulse, 0 falling and 1 rising, only in one-pulse.
// - Bit 1 of each channel register inverts the waveform when 1, reset 0.
// - Bit 0 is set when the counter meets the active duty and cleared by reading the register.
// - Transfer bit two resets to 1 and, in dual mode only, moves duty and polarity at the next counter-two overflow, then clears.
// - Channels 2 and 3 follow transfer bit two in dual mode and transfer bit one otherwise.
// - Transfer bit one resets to 1, clears after each transfer and always serves channels 0 and 1.
// - Bit 7 of the dead-time register enables dead time between complementary channels 0 and 1.
// - The dead time is the 7-bit value times one counter-one clock period.
// - Dead time enabled with a zero value holds channels 0 and 1 at their reset level.
module arp_timer
	import arp_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// capture pin
	input wire logic capturePin,
	// pwm pins
	output logic [NUM_CH-1:0] waveformChannel,
	output logic [NUM_CH-1:0] waveformOe,
	// interrupt
	output logic irq
);

	// register state
	logic [CNT_W-1:0] reloadOneQ, reloadOneD;
	logic [CNT_W-1:0] reloadTwoQ, reloadTwoD;
	logic [NUM_CH-1:0] outEnQ, outEnD;
	logic [NUM_CH-1:0] polQ, polD;
	logic [NUM_CH-1:0] cmpQ, cmpD;
	logic onePulseEnableQ, onePulseEnableD;
	logic edgeSelectQ, edgeSelectD;
	logic [7:0] deadTimeQ, deadTimeD;
	logic tranOneQ, tranOneD;
	logic tranTwoQ, tranTwoD;
	logic dualQ, dualD;
	logic [CNT_W-1:0] dutyPreQ [NUM_CH];
	logic [CNT_W-1:0] dutyPreD [NUM_CH];
	logic [IRQ_W-1:0] irqStatQ, irqStatD;
	logic [IRQ_W-1:0] irqMaskQ, irqMaskD;
	logic ackQ, ackD;
	logic [31:0] datQ, datD;

	// pwm state
	logic [CNT_W-1:0] dutyActQ [NUM_CH];
	logic [CNT_W-1:0] dutyActD [NUM_CH];
	logic [NUM_CH-1:0] polShadowQ, polShadowD;
	logic [NUM_CH-1:0] rawQ, rawD;
	logic [DT_W-1:0] dtCntQ, dtCntD;
	logic [NUM_CH-1:0] pinQ, pinD;

	// one-pulse state
	logic capSyncA, capSyncB, capPrevQ;
	arp_op_state_t opStateQ, opStateD;

	// bus decode
	logic access, wrEn, rdEn;
	logic [IRQ_W-1:0] irqEvent;
	logic [NUM_CH-1:0] matchEv, csrRead;

	// counters
	arp_cnt_t cntOne, cntTwo;
	logic runTwo, restartTwo, trigger;
	logic xferOne, xferTwo, xferHigh;
	logic dtEnable, dtZero;

	assign access = wb_cyc_i && wb_stb_i && !ackQ;
	assign wrEn = access && wb_we_i;
	assign rdEn = access && !wb_we_i;

	// capture pin: two flops, then the edge detector reads the second
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			capSyncA <= 1'b0;
			capSyncB <= 1'b0;
			capPrevQ <= 1'b0;
		end else begin
			capSyncA <= capturePin;
			capSyncB <= capSyncA;
			capPrevQ <= capSyncB;
		end
	end

	// edge choice only matters once one-pulse is on
	assign trigger = onePulseEnableQ && (edgeSelectQ ? (capSyncB && !capPrevQ)
		: (!capSyncB && capPrevQ));

	always_comb begin
		opStateD = opStateQ;
		case (opStateQ)
			OP_IDLE: begin
				if (trigger) begin
					opStateD = OP_RUN;
				end
			end
			OP_RUN: begin
				if (cntTwo.wrap || !onePulseEnableQ) begin
					opStateD = OP_IDLE;
				end
			end
			default: opStateD = OP_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			opStateQ <= OP_IDLE;
		end else begin
			opStateQ <= opStateD;
		end
	end

	// one-pulse drives counter two even outside dual mode
	assign restartTwo = trigger && (opStateQ == OP_IDLE);
	assign runTwo = onePulseEnableQ ? (opStateQ == OP_RUN) : dualQ;

	arp_counter uCountOne (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.run(1'b1),
		.restart(1'b0),
		.reloadValue(reloadOneQ),
		.cnt(cntOne)
	);

	arp_counter uCountTwo (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.run(runTwo),
		.restart(restartTwo),
		.reloadValue(reloadTwoQ),
		.cnt(cntTwo)
	);

	assign xferOne = cntOne.wrap && tranOneQ;
	assign xferTwo = cntTwo.wrap && tranTwoQ && dualQ;
	assign xferHigh = dualQ ? xferTwo : xferOne;

	// duty match per channel, only while the governing counter moves
	generate
		for (genvar i = 0; i < NUM_CH; i++) begin : gMatch
			if (i < 2) begin : gLow
				assign matchEv[i] = cntOne.step && (cntOne.count == dutyActQ[i]);
			end else begin : gHigh
				assign matchEv[i] = (dualQ || onePulseEnableQ)
					? (cntTwo.step && (cntTwo.count == dutyActQ[i]))
					: (cntOne.step && (cntOne.count == dutyActQ[i]));
			end
			assign csrRead[i] = rdEn && (wb_adr_i == OFS_CSR_BASE + 8'(4 * i));
		end
	endgenerate

	assign irqEvent = {matchEv, cntTwo.wrap, cntOne.wrap};

	// register file and bus answer
	always_comb begin
		reloadOneD = reloadOneQ;
		reloadTwoD = reloadTwoQ;
		outEnD = outEnQ;
		polD = polQ;
		onePulseEnableD = onePulseEnableQ;
		edgeSelectD = edgeSelectQ;
		deadTimeD = deadTimeQ;
		dualD = dualQ;
		irqMaskD = irqMaskQ;
		dutyPreD = dutyPreQ;
		ackD = access;
		datD = 32'h0000_0000;
		// a hardware clear loses to a software set in the same cycle
		tranOneD = tranOneQ && !xferOne;
		tranTwoD = tranTwoQ && !xferTwo;
		cmpD = matchEv | (cmpQ & ~csrRead);
		irqStatD = irqStatQ | irqEvent;
		if (wrEn && wb_sel_i[0]) begin
			case (wb_adr_i)
				OFS_RELOAD_ONE_HIGH: reloadOneD[11:8] = wb_dat_i[3:0];
				OFS_RELOAD_ONE_LOW: reloadOneD[7:0] = wb_dat_i[7:0];
				OFS_RELOAD_TWO_HIGH: reloadTwoD[11:8] = wb_dat_i[3:0];
				OFS_RELOAD_TWO_LOW: reloadTwoD[7:0] = wb_dat_i[7:0];
				OFS_OUTPUT_ENABLE: outEnD = wb_dat_i[NUM_CH-1:0];
				OFS_DEAD_TIME: deadTimeD = wb_dat_i[7:0];
				OFS_MODE: dualD = wb_dat_i[DUAL_EN_BIT];
				OFS_IRQ_MASK: irqMaskD = wb_dat_i[IRQ_W-1:0];
				OFS_IRQ_STATUS: irqStatD = irqEvent | (irqStatQ & ~wb_dat_i[IRQ_W-1:0]);
				OFS_TRANSFER: begin
					// writing zero is ignored; only hardware clears
					tranOneD = tranOneD || wb_dat_i[TRAN_ONE_BIT];
					tranTwoD = tranTwoD || wb_dat_i[TRAN_TWO_BIT];
				end
				default: begin
					for (int i = 0; i < NUM_CH; i++) begin
						if (wb_adr_i == OFS_CSR_BASE + 8'(4 * i)) begin
							polD[i] = wb_dat_i[CSR_POL_BIT];
							if (i == OP_CH) begin
								onePulseEnableD = wb_dat_i[CSR_ONE_PULSE_ENABLE_BIT];
								edgeSelectD = wb_dat_i[CSR_EDGE_BIT];
							end
						end
					end
				end
			endcase
		end
		for (int i = 0; i < NUM_CH; i++) begin
			if (wrEn && (wb_adr_i == OFS_DUTY_BASE + 8'(4 * i))) begin
				if (wb_sel_i[0]) begin
					dutyPreD[i][7:0] = wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					dutyPreD[i][11:8] = wb_dat_i[11:8];
				end
			end
		end
		if (rdEn) begin
			case (wb_adr_i)
				OFS_RELOAD_ONE_HIGH: datD[3:0] = reloadOneQ[11:8];
				OFS_RELOAD_ONE_LOW: datD[7:0] = reloadOneQ[7:0];
				OFS_RELOAD_TWO_HIGH: datD[3:0] = reloadTwoQ[11:8];
				OFS_RELOAD_TWO_LOW: datD[7:0] = reloadTwoQ[7:0];
				OFS_OUTPUT_ENABLE: datD[NUM_CH-1:0] = outEnQ;
				OFS_DEAD_TIME: datD[7:0] = deadTimeQ;
				OFS_MODE: datD[DUAL_EN_BIT] = dualQ;
				OFS_IRQ_MASK: datD[IRQ_W-1:0] = irqMaskQ;
				OFS_IRQ_STATUS: datD[IRQ_W-1:0] = irqStatQ;
				OFS_COUNT_ONE: datD[CNT_W-1:0] = cntOne.count;
				OFS_COUNT_TWO: datD[CNT_W-1:0] = cntTwo.count;
				OFS_TRANSFER: begin
					datD[TRAN_ONE_BIT] = tranOneQ;
					datD[TRAN_TWO_BIT] = tranTwoQ;
				end
				default: begin
					for (int i = 0; i < NUM_CH; i++) begin
						if (wb_adr_i == OFS_CSR_BASE + 8'(4 * i)) begin
							datD[CSR_POL_BIT] = polQ[i];
							datD[CSR_CMP_BIT] = cmpQ[i];
							if (i == OP_CH) begin
								datD[CSR_ONE_PULSE_ENABLE_BIT] = onePulseEnableQ;
								datD[CSR_EDGE_BIT] = edgeSelectQ;
							end
						end
						if (wb_adr_i == OFS_DUTY_BASE + 8'(4 * i)) begin
							datD[CNT_W-1:0] = dutyPreQ[i];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			reloadOneQ <= CNT_RST;
			reloadTwoQ <= CNT_RST;
			outEnQ <= RST_BYTE[NUM_CH-1:0];
			polQ <= RST_BYTE[NUM_CH-1:0];
			cmpQ <= RST_BYTE[NUM_CH-1:0];
			onePulseEnableQ <= 1'b0;
			edgeSelectQ <= 1'b0;
			deadTimeQ <= RST_BYTE;
			tranOneQ <= RST_TRANSFER[TRAN_ONE_BIT];
			tranTwoQ <= RST_TRANSFER[TRAN_TWO_BIT];
			dualQ <= 1'b0;
			for (int i = 0; i < NUM_CH; i++) begin
				dutyPreQ[i] <= CNT_RST;
			end
			irqStatQ <= RST_IRQ;
			irqMaskQ <= RST_IRQ;
			ackQ <= 1'b0;
			datQ <= 32'h0000_0000;
		end else begin
			reloadOneQ <= reloadOneD;
			reloadTwoQ <= reloadTwoD;
			outEnQ <= outEnD;
			polQ <= polD;
			cmpQ <= cmpD;
			onePulseEnableQ <= onePulseEnableD;
			edgeSelectQ <= edgeSelectD;
			deadTimeQ <= deadTimeD;
			tranOneQ <= tranOneD;
			tranTwoQ <= tranTwoD;
			dualQ <= dualD;
			dutyPreQ <= dutyPreD;
			irqStatQ <= irqStatD;
			irqMaskQ <= irqMaskD;
			ackQ <= ackD;
			datQ <= datD;
		end
	end

	assign dtEnable = deadTimeQ[DT_EN_BIT];
	assign dtZero = (deadTimeQ[DT_W-1:0] == 7'h00);

	// waveform generation, transfers and dead time
	always_comb begin
		dutyActD = dutyActQ;
		polShadowD = polShadowQ;
		rawD = rawQ;
		dtCntD = dtCntQ;
		for (int i = 0; i < NUM_CH; i++) begin
			if ((i < 2) ? xferOne : xferHigh) begin
				dutyActD[i] = dutyPreQ[i];
				polShadowD[i] = polQ[i];
			end
		end
		// rise at overflow, fall at match; a match on the wrap cycle wins
		// a one-pulse run rises only at its trigger, never at its closing wrap
		for (int i = 0; i < NUM_CH; i++) begin
			if (matchEv[i]) begin
				rawD[i] = 1'b0;
			end else if ((i < 2 || !(dualQ || onePulseEnableQ)) ? cntOne.wrap
				: ((cntTwo.wrap && !onePulseEnableQ) || restartTwo)) begin
				rawD[i] = 1'b1;
			end
		end
		// one-pulse ends low once counter two has stopped
		if (onePulseEnableQ && opStateQ == OP_IDLE && !restartTwo) begin
			rawD[2] = 1'b0;
			rawD[3] = 1'b0;
		end
		// blanking counts in counter-one clocks, which are system clocks here
		if (rawD[0] != rawQ[0]) begin
			dtCntD = deadTimeQ[DT_W-1:0];
		end else if (dtCntQ != 7'h00) begin
			dtCntD = dtCntQ - 7'h01;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			pinD[i] = rawQ[i] ^ polShadowQ[i];
		end
		if (dtEnable) begin
			if (dtZero) begin
				pinD[0] = 1'b0;
				pinD[1] = 1'b0;
			end else begin
				pinD[0] = (rawQ[0] && dtCntQ == 7'h00) ^ polShadowQ[0];
				pinD[1] = (!rawQ[0] && dtCntQ == 7'h00) ^ polShadowQ[1];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				dutyActQ[i] <= CNT_RST;
			end
			polShadowQ <= RST_BYTE[NUM_CH-1:0];
			rawQ <= RST_BYTE[NUM_CH-1:0];
			dtCntQ <= 7'h00;
			pinQ <= RST_BYTE[NUM_CH-1:0];
		end else begin
			dutyActQ <= dutyActD;
			polShadowQ <= polShadowD;
			rawQ <= rawD;
			dtCntQ <= dtCntD;
			pinQ <= pinD;
		end
	end

	assign waveformChannel = pinQ & outEnQ;
	assign waveformOe = outEnQ;
	assign irq = |(irqStatQ & irqMaskQ);
	assign wb_ack_o = ackQ;
	assign wb_dat_o = datQ;

endmodule

// File: sim/arp_timer_checker.sv
// port assertions for the dual auto-reload pwm timer
`timescale 1ns/1ps
module arp_timer_checker
	import arp_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// pins
	input wire logic capturePin,
	input wire logic [NUM_CH-1:0] waveformChannel,
	input wire logic [NUM_CH-1:0] waveformOe,
	input wire logic irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic take;
	logic [7:0] dtQ, dtD, oeQ, oeD;
	// shadow copies of two registers, seen from the bus only
	assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	always_comb begin
		dtD = (take && wb_adr_i == OFS_DEAD_TIME) ? wb_dat_i[7:0] : dtQ;
		oeD = (take && wb_adr_i == OFS_OUTPUT_ENABLE) ? wb_dat_i[7:0] : oeQ;
	end
	always_ff @(posedge clk_sys) begin
		dtQ <= rstn ? dtD : RST_BYTE;
		oeQ <= rstn ? oeD : RST_BYTE;
	end
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not one cycle after request");
	a_reset_quiet: assert property ($rose(rstn) |-> !wb_ack_o && !irq && waveformOe == '0)
		else $error("outputs not quiet after reset");
	a_pin_gated: assert property ((waveformChannel & ~waveformOe) == '0)
		else $error("disabled pin driven");
	a_oe_follow: assert property (oeQ == $past(oeQ, 2) |-> waveformOe == oeQ[NUM_CH-1:0])
		else $error("pin enables differ from register");
	a_write_zero: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == '0)
		else $error("read data on a write");
	a_unmapped_zero: assert property (wb_ack_o && $past(wb_adr_i) > OFS_COUNT_TWO |-> wb_dat_o == '0)
		else $error("unmapped read not zero");
	a_csr_narrow: assert property (wb_ack_o
		&& $past(wb_adr_i) inside {8'h0C, 8'h10, 8'h14} |-> wb_dat_o[7:2] == 6'h00)
		else $error("one-pulse bits outside channel three");
	a_dt_hold: assert property (dtQ == 8'h80 && $past(dtQ, 3) == 8'h80
		|-> waveformChannel[1:0] == 2'h0)
		else $error("zero dead time did not hold pins");
endmodule
bind arp_timer arp_timer_checker u_chk (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .capturePin(capturePin),
	.waveformChannel(waveformChannel), .waveformOe(waveformOe), .irq(irq));

// File: sim/arp_timer_tb_top.sv
// self-checking bench for the dual auto-reload pwm timer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
	$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module arp_timer_tb_top
	import arp_pkg::*;
;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d;
		logic [31:0] m; logic [31:0] e;} arp_row_t;
	logic clk_sys, rstn, cyc, stb, we, ack, capturePin, irq;
	logic [7:0] adr;
	logic [3:0] sel, pin, oe;
	logic [31:0] wdat, rd, rdat;
	int fails, checks, hi, per;
	arp_row_t rows[11] = '{
		'{1'b0, OFS_TRANSFER, 0, 32'hFFFFFFFF, 32'h3},
		'{1'b1, OFS_TRANSFER, 32'h3, 32'hFFFFFFFF, 32'h3},
		'{1'b0, OFS_IRQ_MASK, 0, 32'hFFFFFFFF, 32'h0},
		'{1'b0, OFS_RELOAD_TWO_LOW, 0, 32'hFFFFFFFF, 32'h0},
		'{1'b1, OFS_CSR_BASE, 32'h0E, 32'hFE, 32'h02},
		'{1'b1, 8'h18, 32'h0E, 32'hFE, 32'h0E},
		'{1'b1, 8'h18, 32'h00, 32'hFE, 32'h00},
		'{1'b1, 8'h50, 32'hFF, 32'hFFFFFFFF, 32'h0},
		'{1'b1, OFS_DEAD_TIME, 32'h80, 32'hFFFFFFFF, 32'h80},
		'{1'b1, OFS_OUTPUT_ENABLE, 32'h0F, 32'hFFFFFFFF, 32'h0F},
		'{1'b1, OFS_RELOAD_ONE_LOW, 32'h5C, 32'hFFFFFFFF, 32'h5C}};
	arp_timer dut (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack),
		.capturePin(capturePin), .waveformChannel(pin), .waveformOe(oe), .irq(irq));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic end_sim();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// one classic cycle; ack and data taken as they stand at the rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_sys);
		while (ack !== 1'b1) @(posedge clk_sys);
		rdat = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// high time and period of one pin, starting at a rising edge
	task automatic meas(input int ch);
		hi = 0;
		while (pin[ch] !== 1'b0) @(negedge clk_sys);
		while (pin[ch] !== 1'b1) @(negedge clk_sys);
		while (pin[ch] === 1'b1) begin hi++; @(negedge clk_sys); end
		per = hi;
		while (pin[ch] !== 1'b1) begin per++; @(negedge clk_sys); end
	endtask
	initial begin
		#200000;
		fails++;
		end_sim();
	end
	initial begin
		{rstn, cyc, stb, we, capturePin, adr, wdat} <= '0;
		sel <= 4'hF;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		@(negedge clk_sys);
		`CHK("oe", 4'h0, oe)
		$display("test reset done");
		foreach (rows[i]) begin
			if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 0);
			`CHK("row", rows[i].e, rdat & rows[i].m)
		end
		$display("test rows done");
		bus(1'b1, OFS_DEAD_TIME, 32'h00);
		bus(1'b1, OFS_CSR_BASE, 32'h00);
		bus(1'b1, OFS_RELOAD_ONE_HIGH, 32'h0F);
		bus(1'b1, OFS_RELOAD_ONE_LOW, 32'h00);
		bus(1'b1, OFS_DUTY_BASE, 32'hF40);
		bus(1'b1, OFS_TRANSFER, 32'h3);
		meas(0);
		meas(0);
		`CHK("high0", 64, hi)
		`CHK("period0", 256, per)
		bus(1'b1, OFS_CSR_BASE, 32'h02);
		bus(1'b1, OFS_TRANSFER, 32'h3);
		meas(0);
		meas(0);
		`CHK("high inverted", 192, hi)
		$display("test period done");
		bus(1'b0, OFS_CSR_BASE, 0);
		`CHK("flag set", 1'b1, rdat[0])
		bus(1'b0, OFS_CSR_BASE, 0);
		`CHK("flag cleared", 1'b0, rdat[0])
		bus(1'b1, OFS_IRQ_STATUS, 32'h3F);
		bus(1'b1, OFS_IRQ_MASK, 32'h04);
		@(negedge clk_sys);
		`CHK("irq clear", 1'b0, irq)
		repeat (300) if (irq !== 1'b1) @(negedge clk_sys);
		`CHK("irq raised", 1'b1, irq)
		bus(1'b1, OFS_IRQ_MASK, 32'h00);
		repeat (2) @(negedge clk_sys);
		`CHK("irq masked", 1'b0, irq)
		$display("test flag done");
		bus(1'b1, OFS_RELOAD_TWO_HIGH, 32'h0F);
		bus(1'b1, OFS_RELOAD_TWO_LOW, 32'h00);
		bus(1'b1, OFS_MODE, 32'h1);
		bus(1'b1, OFS_DUTY_BASE + 8'h08, 32'hF40);
		bus(1'b1, OFS_TRANSFER, 32'h3);
		meas(2);
		meas(2);
		`CHK("high2", 64, hi)
		`CHK("period2", 256, per)
		$display("test dual done");
		bus(1'b1, OFS_CSR_BASE, 32'h00);
		bus(1'b1, OFS_TRANSFER, 32'h1);
		bus(1'b1, OFS_DEAD_TIME, 32'h84);
		// let one overflow pass so polarity and blanking are settled
		repeat (300) @(negedge clk_sys);
		meas(0);
		`CHK("dead high0", 60, hi)
		meas(1);
		`CHK("dead high1", 188, hi)
		bus(1'b1, OFS_DEAD_TIME, 32'h80);
		repeat (300) @(negedge clk_sys);
		`CHK("dt hold", 2'h0, pin[1:0])
		$display("test dead time done");
		bus(1'b1, OFS_CSR_BASE + 8'h0C, 32'h0C);
		repeat (3) @(posedge clk_sys);
		capturePin <= 1'b1;
		hi = 0;
		repeat (300) begin
			@(negedge clk_sys);
			if (pin[2] === 1'b1) hi++;
		end
		// one pulse spans reload up to the duty match, both ends included
		`CHK("one pulse", 65, hi)
		$display("test one pulse done");
		end_sim();
	end
endmodule
